// File: include/bwm_pkg.sv
// shared constants and types for the burst write byte mask block
package bwm_pkg;
   localparam int LANE_W = 9;
   localparam int LANES_MAX = 4;
   localparam int DATA_W = LANE_W * LANES_MAX;
   localparam int ADDR_W = 8;
   localparam int BEATS = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = ADDR_W + ADDR_W + LANES_MAX + DATA_W;
   localparam logic [DATA_W-1:0] MEM_RESET = 36'h0_0000_0000;
   localparam logic [LANES_MAX-1:0] SEL_NONE = 4'hF;
   typedef enum logic {ORG_18, ORG_36} bwm_org_type;
endpackage : bwm_pkg

// File: hw/bwm_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
module bwm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   // handshakes
   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = store[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage write
   always_ff @(posedge CLK) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : bwm_fifo

// File: hw/bwm_top.sv
// burst write with per-lane byte masking into a small sram array
// Behaviour
// - 18-bit mode: select 0 low writes bits 8:0, select 1 low bits 17:9.
// - 18-bit mode: lane with select high keeps its old contents.
// - 18-bit mode: both selects high, nothing stored for that beat.
// - 36-bit mode: selects 0..3 enable lanes 8:0, 17:9, 26:18, 35:27.
// - 36-bit mode: lanes with select high retain their prior value.
// - 36-bit mode: all four selects high, no storage that beat.
// - selects active low, evaluated once per beat on both clock edges.
// - selects ignored outside a properly started write burst.
// - data and selects captured together on both clock rising edges.
// - beats go to address A, A+1, A+2, A+3 in order.
module bwm_top
   import bwm_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // configuration
   input wire logic ORG_WIDE,
   // write port, sampled on rises of the true and complementary input clock
   input wire logic K_IN,
   input wire logic K_N_IN,
   input wire logic WRITE_PORT_SELECT_N,
   input wire logic [bwm_pkg::ADDR_W-1:0] ADDR,
   input wire logic [bwm_pkg::DATA_W-1:0] DATA,
   input wire logic [bwm_pkg::LANES_MAX-1:0] BYTE_WRITE_SELECT_N,
   // array read-back
   input wire logic [bwm_pkg::ADDR_W-1:0] RD_ADDR,
   output logic [bwm_pkg::DATA_W-1:0] RD_DATA,
   // status
   output logic BUSY,
   output logic OVERFLOW
);
   import bwm_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DATA} bwm_state_type;

   logic [2:0] k_sync;
   logic [2:0] kn_sync;
   logic [1:0] wps_sync;
   logic [ADDR_W-1:0] addr_sync [2];
   logic [DATA_W-1:0] data_sync [2];
   logic [LANES_MAX-1:0] sel_sync [2];
   logic k_rise;
   logic kn_rise;
   logic edge_any;
   bwm_state_type state;
   logic [1:0] beat;
   logic [ADDR_W-1:0] base;
   logic start_prev;
   logic start_take;
   logic [1:0] org_sync;
   logic fill_valid;
   logic fill_ready;
   logic [FIFO_W-1:0] fill_data;
   logic drain_valid;
   logic drain_ready;
   logic [FIFO_W-1:0] drain_data;
   logic [DATA_W-1:0] mem [1 << ADDR_W];
   logic [ADDR_W-1:0] d_addr;
   logic [DATA_W-1:0] d_data;
   logic [LANES_MAX-1:0] d_sel;
   logic [ADDR_W-1:0] d_beat_addr;
   logic [DATA_W-1:0] d_mask;

   // effective lane enables: unused upper lanes forced off in narrow mode
   function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES_MAX-1:0] sel_n, input logic wide);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < LANES_MAX; i++) begin
         if (!sel_n[i] && (wide || i < 2)) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{1'b1}};
         end
      end
      return m;
   endfunction : lane_mask

   // two-stage synchronisers for the pin-side inputs
   // data, address and selects pass the same two stages as the clocks, so a beat
   // is taken with the levels that stood at its edge; pins must hold a few cycles
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         k_sync <= '0;
         kn_sync <= 3'h7; // idle level of the complementary pin is high
         wps_sync <= 2'h3;
         addr_sync <= '{default: '0};
         data_sync <= '{default: '0};
         sel_sync <= '{default: SEL_NONE};
      end else begin
         k_sync <= {k_sync[1:0], K_IN};
         kn_sync <= {kn_sync[1:0], K_N_IN};
         wps_sync <= {wps_sync[0], WRITE_PORT_SELECT_N};
         addr_sync <= '{ADDR, addr_sync[0]};
         data_sync <= '{DATA, data_sync[0]};
         sel_sync <= '{BYTE_WRITE_SELECT_N, sel_sync[0]};
      end
   end

   // organisation pin synchronised like the others; hold it static across bursts
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         org_sync <= '0;
      end else begin
         org_sync <= {org_sync[0], ORG_WIDE};
      end
   end

   // edges seen only after the second stage
   assign k_rise = k_sync[1] && !k_sync[2];
   assign kn_rise = kn_sync[1] && !kn_sync[2];
   assign edge_any = k_rise || kn_rise;

   // a start is taken only in idle, at a true rise, not right after another start
   assign start_take = (state == ST_IDLE) && k_rise && !wps_sync[1] && !start_prev;

   // remembers a start until the next true rise, so a back-to-back request is refused
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         start_prev <= 1'b0;
      end else if (start_take) begin
         start_prev <= 1'b1;
      end else if (k_rise) begin
         start_prev <= 1'b0;
      end
   end

   // burst sequencer: latch on true rise, beats start on next true rise
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ST_IDLE;
         beat <= '0;
         base <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_take) begin
                  base <= addr_sync[1];
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (k_rise) begin
                  beat <= 2'h1;
                  state <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (edge_any) begin
                  beat <= beat + 2'h1;
                  if (beat == 2'(BEATS-1)) begin
                     state <= ST_IDLE;
                     beat <= '0;
                  end
               end
            end
         endcase
      end
   end

   // one fifo entry per data beat, carrying its own select pattern
   assign fill_valid = (state == ST_WAIT && k_rise) || (state == ST_DATA && edge_any);
   assign fill_data = {base, ADDR_W'((state == ST_WAIT) ? 2'h0 : beat), sel_sync[1], data_sync[1]};

   bwm_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .CLK(CLK),
      .ARST_N(ARST_N),
      .in_valid(fill_valid),
      .in_ready(fill_ready),
      .in_data(fill_data),
      .out_valid(drain_valid),
      .out_ready(drain_ready),
      .out_data(drain_data)
   );

   // drain never stalls: the merge below takes one word every cycle
   assign drain_ready = 1'b1;
   assign d_data = drain_data[DATA_W-1:0];
   assign d_sel = drain_data[DATA_W +: LANES_MAX];
   assign d_addr = drain_data[FIFO_W-1 -: ADDR_W];
   assign d_beat_addr = d_addr + drain_data[FIFO_W-ADDR_W-1 -: ADDR_W];
   assign d_mask = lane_mask(d_sel, org_sync[1]);

   // masked merge into the addressed word only
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mem <= '{default: MEM_RESET};
      end else if (drain_valid && d_mask != '0) begin
         mem[d_beat_addr] <= (mem[d_beat_addr] & ~d_mask) | (d_data & d_mask);
      end
   end

   // read-back port: one cycle behind the address
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RD_DATA <= '0;
      end else begin
         RD_DATA <= mem[RD_ADDR];
      end
   end

   // busy while a burst runs or beats still wait in the fifo
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         BUSY <= 1'b0;
      end else begin
         BUSY <= (state != ST_IDLE) || drain_valid;
      end
   end

   // sticky overflow: a beat met a full fifo, cleared only by reset
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         OVERFLOW <= 1'b0;
      end else if (fill_valid && !fill_ready) begin
         OVERFLOW <= 1'b1;
      end
   end
endmodule : bwm_top

// File: dv/bwm_top_monitor.sv
// assertion checker for the burst write byte mask top ports
module bwm_top_monitor
   import bwm_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // watched ports
   input wire logic K_IN,
   input wire logic WRITE_PORT_SELECT_N,
   input wire logic [bwm_pkg::ADDR_W-1:0] RD_ADDR,
   input wire logic [bwm_pkg::DATA_W-1:0] RD_DATA,
   input wire logic BUSY,
   input wire logic OVERFLOW
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   // start seen with the true clock high two cycles earlier, and an idle stretch
   sequence start_seen; $past(K_IN, 2) && !$past(WRITE_PORT_SELECT_N, 2); endsequence
   sequence quiet; !BUSY [*3]; endsequence
   // status and array behaviour
   a_reset_clear: assert property ($rose(ARST_N) |-> !BUSY && !OVERFLOW && RD_DATA == '0)
      else $error("status not clear after reset");
   a_ovf_sticky: assert property (OVERFLOW |=> OVERFLOW) else $error("overflow dropped");
   a_ovf_cause: assert property ($rose(OVERFLOW) |-> $past(BUSY)) else $error("overflow while idle");
   a_start_cause: assert property ($rose(BUSY) |-> start_seen)
      else $error("busy without start");
   a_burst_span: assert property ($rose(BUSY) |-> BUSY [*8])
      else $error("burst too short");
   a_fall_span: assert property ($fell(BUSY) |-> $past(BUSY, 8))
      else $error("busy fell early");
   a_idle_ignore: assert property ((!BUSY && WRITE_PORT_SELECT_N) [*6] |=> !BUSY)
      else $error("busy without select");
   a_quiet_hold: assert property (quiet ##0 $stable(RD_ADDR) |=> $stable(RD_DATA))
      else $error("array changed while idle");
endmodule : bwm_top_monitor

// File: dv/bwm_ctl_model.sv
// controller model driving the write port of the byte mask block
module bwm_ctl_model
   import bwm_pkg::*;
(
   // system clock
   input wire logic CLK,
   // write port pins, idle at time zero
   output logic K_IN = 1'b0,
   output logic K_N_IN = 1'b1,
   output logic WRITE_PORT_SELECT_N = 1'b1,
   output logic [bwm_pkg::ADDR_W-1:0] ADDR = 8'h00,
   output logic [bwm_pkg::DATA_W-1:0] DATA = 36'h0_0000_0000,
   output logic [bwm_pkg::LANES_MAX-1:0] BYTE_WRITE_SELECT_N = 4'hF
);
   timeunit 1ns;
   timeprecision 1ns;
   // one half period: pins settle, then one of the two clocks rises
   task automatic half(input logic k, input logic w, input logic [7:0] a, input logic [35:0] d, input logic [3:0] s);
      @(posedge CLK);
      WRITE_PORT_SELECT_N <= w;
      ADDR <= a;
      DATA <= d;
      BYTE_WRITE_SELECT_N <= s;
      repeat (4) @(posedge CLK);
      K_IN <= k;
      K_N_IN <= ~k;
      repeat (3) @(posedge CLK);
   endtask : half
   // start, spare complementary rise, then four beats with their own selects
   task automatic burst(input logic [7:0] a, input logic [35:0] d, input logic [15:0] s, input logic w2);
      half(1'b1, 1'b0, a, ~d, SEL_NONE);
      half(1'b0, w2, ~a, ~d, 4'h0);
      for (int i = 0; i < 4; i++) begin
         half(~i[0], w2, ~a, d + 36'(i), s[4*i+:4]);
      end
   endtask : burst
endmodule : bwm_ctl_model

// File: dv/bwm_top_tb_top.sv
// self-checking bench for the burst write byte mask block
module bwm_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import bwm_pkg::*;
   typedef struct packed {logic wide; logic [7:0] addr; logic [35:0] data; logic [15:0] sel; logic w2;} bwm_row_type;
   logic clk, k_in, k_n_in, wps_n, busy, ovf;
   logic arst_n = 1'b0;
   logic org = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] rd_addr = 8'h00;
   logic [DATA_W-1:0] data, rd_data;
   logic [LANES_MAX-1:0] sel_n;
   logic [DATA_W-1:0] shadow [256] = '{default: 36'h0_0000_0000};
   int mismatches = 0;
   int n_tests = 0;
   bwm_row_type rows [5] = '{'{1'b0, 8'h10, 36'h1_2345_6789, 16'hFDE0, 1'b1},
      '{1'b0, 8'h12, 36'hF_0F0F_0F0F, 16'hEDF0, 1'b0}, '{1'b1, 8'h20, 36'hA_BCDE_F012, 16'hBDE0, 1'b1},
      '{1'b1, 8'h22, 36'h5_A5A5_A5A5, 16'h0EF7, 1'b0}, '{1'b1, 8'hFC, 36'h3_C3C3_C3C3, 16'hFFFF, 1'b1}};
   bwm_top u_dut (.CLK(clk), .ARST_N(arst_n), .ORG_WIDE(org), .K_IN(k_in), .K_N_IN(k_n_in),
      .WRITE_PORT_SELECT_N(wps_n), .ADDR(addr), .DATA(data), .BYTE_WRITE_SELECT_N(sel_n),
      .RD_ADDR(rd_addr), .RD_DATA(rd_data), .BUSY(busy), .OVERFLOW(ovf));
   bwm_ctl_model u_ctl (.CLK(clk), .K_IN(k_in), .K_N_IN(k_n_in), .WRITE_PORT_SELECT_N(wps_n),
      .ADDR(addr), .DATA(data), .BYTE_WRITE_SELECT_N(sel_n));
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // expected word: enabled lanes take new data
   function automatic logic [35:0] merge(logic [35:0] old, logic [35:0] d, logic [3:0] s, logic w);
      for (int i = 0; i < LANES_MAX; i++) begin
         if (!s[i] && (w || i < 2))
            old[9*i+:9] = d[9*i+:9];
      end
      return old;
   endfunction : merge
   task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic check_word(input logic [7:0] a);
      @(posedge clk);
      rd_addr <= a;
      repeat (2) @(posedge clk);
      cmp(rd_data, shadow[a]);
   endtask : check_word
   task automatic wait_idle;
      for (int n = 0; n < 100 && busy !== 1'b0; n++) begin
         @(posedge clk);
      end
      cmp({34'h0, busy, ovf}, 36'h0_0000_0000);
   endtask : wait_idle
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
   // table of bursts, then stray selects and a mid-run reset
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int r = 0; r < 5; r++) begin
         @(posedge clk);
         org <= rows[r].wide;
         u_ctl.burst(rows[r].addr, rows[r].data, rows[r].sel, rows[r].w2);
         for (int i = 0; i < 4; i++) begin
            shadow[8'(rows[r].addr + i)] = merge(shadow[8'(rows[r].addr + i)], rows[r].data + 36'(i),
               rows[r].sel[4*i+:4], rows[r].wide);
         end
         wait_idle();
         for (int j = -1; j < 5; j++) begin
            check_word(8'(rows[r].addr + j));
         end
         check_word(~rows[r].addr);
         $display("row %0d done", r);
      end
      u_ctl.half(1'b1, 1'b1, 8'h30, 36'hF_FFFF_FFFF, 4'h0);
      u_ctl.half(1'b0, 1'b0, 8'h30, 36'hF_FFFF_FFFF, 4'h0);
      wait_idle();
      check_word(8'h30);
      $display("stray selects done");
      arst_n <= 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      shadow = '{default: 36'h0_0000_0000};
      repeat (3) @(posedge clk);
      check_word(8'h20);
      wait_idle();
      $display("reset done");
      tally_and_finish();
   end
endmodule : bwm_top_tb_top
bind bwm_top bwm_top_monitor u_mon (.CLK(CLK), .ARST_N(ARST_N), .K_IN(K_IN), .WRITE_PORT_SELECT_N(WRITE_PORT_SELECT_N),
   .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .BUSY(BUSY), .OVERFLOW(OVERFLOW));
